// >>> logic/mps_sequencer.sv
// power sequencer: off/on/sleep state machine, carrier permit and system reset
`timescale 1ns/1ps
module mps_sequencer (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic power_button_in_n_i,
  input wire logic vin_good_in_i,
  input wire logic sw_running_i,
  input wire logic sw_shutdown_req_i,
  input wire logic sw_sleep_req_i,
  input wire logic deep_sleep_mode_i,
  input wire logic [mps_pkg::MPS_TMR_W-1:0] sleep_timer_load_i,
  input wire logic sleep_timer_en_i,
  input wire logic over_temp_i,
  input wire logic temp_limit_i,
  input wire logic brown_out_i,
  input wire logic low_supply_i,
  input wire logic usb_vbus_i,
  input wire logic usb_vbus_wake_en_i,
  input wire logic sd_detect_i,
  input wire logic sd_detect_wake_en_i,
  input wire logic [mps_pkg::MPS_NWAKE-1:0] conn_wake_i,
  input wire logic [mps_pkg::MPS_NWAKE-1:0] conn_wake_en_i,
  input wire logic [mps_pkg::MPS_NWAKE-1:0] io_out_i,
  output logic carrier_power_permit_o,
  output logic system_reset_out_n_o,
  output logic module_power_en_o,
  output logic [1:0] power_state_o,
  output logic deep_sleep_active_o,
  output logic [mps_pkg::MPS_NWAKE-1:0] io_out_o,
  output logic [2:0] wake_cause_o
);
  import mps_pkg::*;

  mps_state_t state_reg;
  mps_state_t state_next;
  logic btn_n_sync;
  logic vin_sync;
  logic vbus_sync;
  logic sd_sync;
  logic [MPS_NWAKE-1:0] conn_sync;
  logic btn_n_prev_reg;
  logic btn_rise;
  logic hold_done;
  logic settle_done;
  logic settle_run;
  logic hw_off_evt;
  logic wake_evt;
  logic timer_wake;
  logic [MPS_TMR_W-1:0] timer_reg;
  logic timer_armed_reg;
  logic [2:0] cause_next;

  // outside state code; transitional steps keep the previous code
  function automatic logic [1:0] mps_code(input mps_state_t s, input logic [1:0] prev);
    logic [1:0] code;
    code = prev;
    case (s)
      MPS_ON: code = 2'h1;
      MPS_SLEEP: code = 2'h2;
      MPS_OFF: code = 2'h0;
      default: code = prev;
    endcase
    return code;
  endfunction

  // true on the edge that moves the machine from one given state to another
  function automatic logic mps_step(input mps_state_t cur, input mps_state_t nxt,
    input mps_state_t from, input mps_state_t to);
    return (cur == from) && (nxt == to);
  endfunction

  // input synchronisers for button, vin good and external wake pins
  mps_sync #(.RST_VAL(1'b1)) u_btn_sync (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .d_i(power_button_in_n_i), .q_o(btn_n_sync));
  mps_sync #(.RST_VAL(1'b0)) u_vin_sync (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .d_i(vin_good_in_i), .q_o(vin_sync));
  mps_sync #(.RST_VAL(1'b0)) u_vbus_sync (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .d_i(usb_vbus_i), .q_o(vbus_sync));
  mps_sync #(.RST_VAL(1'b0)) u_sd_sync (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .d_i(sd_detect_i), .q_o(sd_sync));

  // one synchroniser per connector wake pin
  genvar gi;
  generate
    for (gi = 0; gi < MPS_NWAKE; gi++) begin : g_conn
      mps_sync #(.RST_VAL(1'b0)) u_conn_sync (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .d_i(conn_wake_i[gi]), .q_o(conn_sync[gi]));
    end
  endgenerate

  // button edge detect on the synchronised level; reset value avoids a false edge
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      btn_n_prev_reg <= MPS_RST_HIGH; // idle level of the released button
    end else begin
      btn_n_prev_reg <= btn_n_sync;
    end
  end
  assign btn_rise = btn_n_sync & ~btn_n_prev_reg;

  // ten second long press while on
  mps_counter u_hold (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .run_i((state_reg == MPS_ON) && !btn_n_sync),
    .limit_i(MPS_HOLD_CYC), .done_o(hold_done));

  // settle delay in the two sequencing steps
  assign settle_run = (state_reg == MPS_UP_PERMIT) || (state_reg == MPS_DN_RESET);
  mps_counter u_settle (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .run_i(settle_run),
    .limit_i(MPS_SETTLE_CYC), .done_o(settle_done));

  // hardware off events acted on in every state but the two shutdown steps
  assign hw_off_evt = over_temp_i | brown_out_i;

  // sleep timer, loaded on sleep entry and counting down during sleep
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer_reg <= '0;
    end else if (mps_step(state_reg, state_next, MPS_ON, MPS_SLEEP)) begin
      timer_reg <= sleep_timer_load_i;
    end else if (state_reg == MPS_SLEEP && timer_armed_reg && timer_reg != '0) begin
      timer_reg <= timer_reg - 1'b1;
    end
  end

  // timer arm flag, taken at sleep entry and dropped once out of sleep
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer_armed_reg <= MPS_RST_LOW;
    end else if (mps_step(state_reg, state_next, MPS_ON, MPS_SLEEP)) begin
      timer_armed_reg <= sleep_timer_en_i;
    end else if (state_reg != MPS_SLEEP) begin
      timer_armed_reg <= MPS_RST_LOW;
    end
  end
  assign timer_wake = timer_armed_reg && (timer_reg == '0);

  // wake sources gathered; vbus, sd detect and connector pins each gated by its own enable
  always_comb begin
    cause_next = 3'h0;
    if (timer_wake) begin
      cause_next = 3'h1;
    end else if (temp_limit_i) begin
      cause_next = 3'h2;
    end else if (low_supply_i) begin
      cause_next = 3'h3;
    end else if (vbus_sync && usb_vbus_wake_en_i) begin
      cause_next = 3'h4;
    end else if (sd_sync && sd_detect_wake_en_i) begin
      cause_next = 3'h5;
    end else if (|(conn_sync & conn_wake_en_i)) begin
      cause_next = 3'h6;
    end else if (btn_rise) begin
      cause_next = 3'h7;
    end
  end
  assign wake_evt = (cause_next != 3'h0);

  // next state decode
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MPS_OFF: begin
        if (btn_rise && vin_sync && !hw_off_evt) begin
          state_next = MPS_UP_PERMIT;
        end
      end
      MPS_UP_PERMIT: begin
        if (hw_off_evt) begin
          state_next = MPS_DN_RESET;
        end else if (settle_done) begin
          state_next = MPS_ON;
        end
      end
      MPS_ON: begin
        if (hw_off_evt || hold_done || (sw_shutdown_req_i && sw_running_i)) begin
          state_next = MPS_DN_RESET;
        end else if (sw_sleep_req_i && sw_running_i) begin
          state_next = MPS_SLEEP;
        end
      end
      MPS_SLEEP: begin
        if (hw_off_evt) begin
          state_next = MPS_DN_RESET;
        end else if (wake_evt) begin
          state_next = MPS_ON;
        end
      end
      MPS_DN_RESET: begin
        if (settle_done) begin
          state_next = MPS_DN_DROP;
        end
      end
      MPS_DN_DROP: begin
        state_next = MPS_OFF;
      end
      default: begin
        state_next = MPS_OFF;
      end
    endcase
  end

  // state register, off after reset
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= MPS_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // carrier permit: raised with own power, dropped only after reset is held
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      carrier_power_permit_o <= MPS_RST_LOW;
    end else begin
      case (state_next)
        MPS_UP_PERMIT: begin
          carrier_power_permit_o <= MPS_RST_HIGH;
        end
        MPS_DN_DROP: begin
          carrier_power_permit_o <= MPS_RST_LOW;
        end
        MPS_OFF: begin
          carrier_power_permit_o <= MPS_RST_LOW;
        end
        default: begin
          carrier_power_permit_o <= carrier_power_permit_o; // sleep keeps level
        end
      endcase
    end
  end

  // system reset: held through the settle, released in on, asserted first on shutdown
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      system_reset_out_n_o <= MPS_RST_LOW;
    end else begin
      case (state_next)
        MPS_UP_PERMIT: begin
          system_reset_out_n_o <= MPS_RST_LOW;
        end
        MPS_ON: begin
          system_reset_out_n_o <= MPS_RST_HIGH;
        end
        MPS_DN_RESET: begin
          system_reset_out_n_o <= MPS_RST_LOW;
        end
        MPS_OFF: begin
          system_reset_out_n_o <= MPS_RST_LOW;
        end
        default: begin
          system_reset_out_n_o <= system_reset_out_n_o;
        end
      endcase
    end
  end

  // own power: on from permit raise until the shutdown completes
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      module_power_en_o <= MPS_RST_LOW;
    end else begin
      case (state_next)
        MPS_UP_PERMIT: begin
          module_power_en_o <= MPS_RST_HIGH;
        end
        MPS_OFF: begin
          module_power_en_o <= MPS_RST_LOW;
        end
        default: begin
          module_power_en_o <= module_power_en_o;
        end
      endcase
    end
  end

  // general outputs follow software in on, freeze in sleep
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_out_o <= '0;
    end else if (state_reg == MPS_ON && state_next == MPS_ON) begin
      io_out_o <= io_out_i;
    end else if (state_next == MPS_OFF) begin
      io_out_o <= '0;
    end
  end

  // state code, held through the transitional steps
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      power_state_o <= 2'h0;
    end else begin
      power_state_o <= mps_code(state_next, power_state_o);
    end
  end

  // deep sleep flag taken at sleep entry, cleared on leaving sleep
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      deep_sleep_active_o <= MPS_RST_LOW;
    end else if (mps_step(state_reg, state_next, MPS_ON, MPS_SLEEP)) begin
      deep_sleep_active_o <= deep_sleep_mode_i;
    end else if (state_next != MPS_SLEEP) begin
      deep_sleep_active_o <= MPS_RST_LOW;
    end
  end

  // cause of the latest wake, kept until the next one
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_cause_o <= 3'h0;
    end else if (mps_step(state_reg, state_next, MPS_SLEEP, MPS_ON)) begin
      wake_cause_o <= cause_next;
    end
  end
endmodule

// >>> logic/mps_pkg.sv
// package: states, timing constants and sequencing counts for the power sequencer
package mps_pkg;
  // power states gray coded along the usual path, except the two-bit step from MPS_DN_DROP to MPS_OFF
  typedef enum logic [2:0] {
    MPS_OFF = 3'h0,
    MPS_UP_PERMIT = 3'h1,
    MPS_ON = 3'h3,
    MPS_SLEEP = 3'h2,
    MPS_DN_RESET = 3'h7,
    MPS_DN_DROP = 3'h6
  } mps_state_t;

  localparam int unsigned MPS_CLK_HZ = 10000000;
  // button hold time for forced off, in seconds
  localparam int unsigned MPS_HOLD_S = 10;
  localparam longint unsigned MPS_HOLD_CYC_L = longint'(MPS_HOLD_S) * longint'(MPS_CLK_HZ);
  localparam logic [31:0] MPS_HOLD_CYC = MPS_HOLD_CYC_L[31:0];
  // settle time between permit and reset release, and reset and permit drop (cycles)
  localparam logic [31:0] MPS_SETTLE_CYC = 32'h0000_0010;
  // timer width for the sleep wake timer
  localparam int unsigned MPS_TMR_W = 32;
  // number of programmable connector wake pins
  localparam int unsigned MPS_NWAKE = 4;
  // reset values
  localparam logic MPS_RST_LOW = 1'b0;
  localparam logic MPS_RST_HIGH = 1'b1;
  localparam logic [31:0] MPS_CNT_ZERO = 32'h0000_0000;
endpackage

// >>> logic/mps_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module mps_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_reg;

  // first stage feeds only the second; reset level is the pin's idle level
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_reg <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// >>> logic/mps_counter.sv
// saturating hold counter: counts while run is high, clears otherwise
`timescale 1ns/1ps
module mps_counter (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic run_i,
  input wire logic [31:0] limit_i,
  output logic done_o
);
  logic [31:0] cnt_reg;

  // count up to the limit, then hold done
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_reg <= 32'h0000_0000;
      done_o <= 1'b0;
    end else if (!run_i) begin
      cnt_reg <= 32'h0000_0000;
      done_o <= 1'b0;
    end else if (cnt_reg >= limit_i - 32'h0000_0001) begin
      done_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end
endmodule

// >>> tb/mps_asserts.sv
// checker: sequencing, sleep hold and shutdown properties
`timescale 1ns/1ps
module mps_asserts
  import mps_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sw_running_i,
  input wire logic sw_shutdown_req_i,
  input wire logic over_temp_i,
  input wire logic brown_out_i,
  input wire logic carrier_power_permit_o,
  input wire logic system_reset_out_n_o,
  input wire logic module_power_en_o,
  input wire logic [1:0] power_state_o,
  input wire logic [mps_pkg::MPS_NWAKE-1:0] io_out_o,
  input wire logic [2:0] wake_cause_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // permit settles before reset release, reset before permit drop
  property p_permit_first; $rose(system_reset_out_n_o) |-> $past(carrier_power_permit_o, 8); endproperty
  a_permit_first: assert property (p_permit_first) else $error("reset released early");
  property p_reset_first; $fell(carrier_power_permit_o) |-> !$past(system_reset_out_n_o, 8); endproperty
  a_reset_first: assert property (p_reset_first) else $error("permit dropped early");
  property p_power_off; $fell(carrier_power_permit_o) |-> ##[1:2] !module_power_en_o; endproperty
  a_power_off: assert property (p_power_off) else $error("own power stays on");
  property p_power_last; $fell(module_power_en_o) |-> !carrier_power_permit_o && !system_reset_out_n_o; endproperty
  a_power_last: assert property (p_power_last) else $error("own power off too soon");
  property p_codes; power_state_o != 2'h3; endproperty
  a_codes: assert property (p_codes) else $error("bad state code");
  property p_permit_off; $rose(carrier_power_permit_o) |-> power_state_o == 2'h0; endproperty
  a_permit_off: assert property (p_permit_off) else $error("power-up outside off");
  // sleep entry, hold and exit
  property p_sleep_from_on;
    power_state_o == 2'h2 && $past(power_state_o) != 2'h2 |-> $past(power_state_o) == 2'h1;
  endproperty
  a_sleep_from_on: assert property (p_sleep_from_on) else $error("sleep not from on");
  property p_sleep_hold;
    power_state_o == 2'h2 && $past(power_state_o) == 2'h2 && system_reset_out_n_o
      |-> $stable(io_out_o) && $stable(carrier_power_permit_o);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("output moved in sleep");
  property p_wake_cause; power_state_o == 2'h1 && $past(power_state_o) == 2'h2 |-> wake_cause_o != 3'h0; endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without cause");
  // shutdown requests
  property p_sw_off;
    power_state_o == 2'h1 && system_reset_out_n_o && sw_running_i && sw_shutdown_req_i |=> !system_reset_out_n_o;
  endproperty
  a_sw_off: assert property (p_sw_off) else $error("sw shutdown ignored");
  property p_hw_off; (over_temp_i || brown_out_i) && system_reset_out_n_o |=> !system_reset_out_n_o; endproperty
  a_hw_off: assert property (p_hw_off) else $error("hw shutdown ignored");
  c_sleep: cover property (power_state_o == 2'h2);
  c_boot: cover property ($rose(system_reset_out_n_o));
  c_down: cover property ($fell(carrier_power_permit_o));
endmodule
bind mps_sequencer mps_asserts u_chk (.clk_i, .sys_rst_i, .sw_running_i, .sw_shutdown_req_i, .over_temp_i,
  .brown_out_i, .carrier_power_permit_o, .system_reset_out_n_o, .module_power_en_o, .power_state_o, .io_out_o,
  .wake_cause_o);

// >>> tb/mps_carrier_model.sv
// partner: carrier board supply control and vin-good source
`timescale 1ns/1ps
module mps_carrier_model #(parameter int VIN_SETTLE = 20) (
  input wire logic clk_i,
  input wire logic vin_present_i,
  input wire logic carrier_power_permit_i,
  output logic vin_good_o,
  output logic carrier_rail_on_o
);
  int settle_cnt = 0;
  // vin counted steady before it is reported good
  always @(negedge clk_i) begin
    if (!vin_present_i)
      settle_cnt <= 0;
    else if (settle_cnt < VIN_SETTLE)
      settle_cnt <= settle_cnt + 1;
  end
  assign vin_good_o = (settle_cnt == VIN_SETTLE);
  // rails off until permit seen, off again once it drops
  assign carrier_rail_on_o = carrier_power_permit_i;
endmodule

// >>> tb/tb.sv
// testbench: power-up, sleep and wake, shutdown sequences
`timescale 1ns/1ps
module tb;
  import mps_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic btn_n = 1'b1, vin_on = 1'b0, sw_run = 1'b0, sw_off = 1'b0, sw_slp = 1'b0, deep = 1'b0;
  logic tmr_en = 1'b0, ot = 1'b0, bo = 1'b0;
  logic [31:0] tmr_ld = 32'h0;
  logic [4:0] src = 5'h0;
  logic [2:0] en = 3'h0;
  logic [3:0] io_in = 4'h0;
  logic vin_good, rail_on, permit, rst_n, pwr_en, deep_act;
  logic [1:0] state;
  logic [3:0] io_out;
  logic [2:0] cause;
  int err_total = 0;
  int check_count = 0;
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  mps_carrier_model #(.VIN_SETTLE(20)) u_carrier (.clk_i(clk_i), .vin_present_i(vin_on),
    .carrier_power_permit_i(permit), .vin_good_o(vin_good), .carrier_rail_on_o(rail_on));
  mps_sequencer DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .power_button_in_n_i(btn_n), .vin_good_in_i(vin_good),
    .sw_running_i(sw_run), .sw_shutdown_req_i(sw_off), .sw_sleep_req_i(sw_slp), .deep_sleep_mode_i(deep),
    .sleep_timer_load_i(tmr_ld), .sleep_timer_en_i(tmr_en), .over_temp_i(ot), .temp_limit_i(src[0]),
    .brown_out_i(bo), .low_supply_i(src[1]), .usb_vbus_i(src[2]), .usb_vbus_wake_en_i(en[0]), .sd_detect_i(src[3]),
    .sd_detect_wake_en_i(en[1]), .conn_wake_i({3'h0, src[4]}), .conn_wake_en_i({3'h0, en[2]}), .io_out_i(io_in),
    .carrier_power_permit_o(permit), .system_reset_out_n_o(rst_n), .module_power_en_o(pwr_en),
    .power_state_o(state), .deep_sleep_active_o(deep_act), .io_out_o(io_out), .wake_cause_o(cause));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wait_state(input logic [1:0] s);
    for (int i = 0; i < 400 && state !== s; i++) @(negedge clk_i);
    chk("state", {30'h0, state}, {30'h0, s});
  endtask
  // press and release the button: release is the rising edge
  task automatic press;
    btn_n = 1'b0;
    tick(5);
    btn_n = 1'b1;
    tick(5);
  endtask
  task automatic power_up;
    press();
    wait_state(2'h1);
    chk("permit", {31'h0, permit}, 32'h1);
    chk("rail_on", {31'h0, rail_on}, 32'h1);
    chk("rst_n", {31'h0, rst_n}, 32'h1);
  endtask
  task automatic sleep_in;
    sw_slp = 1'b1;
    tick(1);
    sw_slp = 1'b0;
    wait_state(2'h2);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    tick(12);
    sys_rst_i = 1'b0;
    tick(2);
    chk("rst_n", {31'h0, rst_n}, 32'h0);
    press();
    tick(30);
    chk("permit", {31'h0, permit}, 32'h0);
    $display("test no_vin done");
    vin_on = 1'b1;
    sw_run = 1'b1;
    tick(30);
    power_up();
    press();
    chk("state", {30'h0, state}, 32'h1);
    sw_run = 1'b0;
    sw_off = 1'b1;
    tick(20);
    chk("state", {30'h0, state}, 32'h1);
    sw_off = 1'b0;
    sw_run = 1'b1;
    io_in = 4'h5;
    tick(2);
    sleep_in();
    io_in = 4'hA;
    tick(20);
    chk("io_out", {28'h0, io_out}, 32'h5);
    chk("state", {30'h0, state}, 32'h2);
    press();
    wait_state(2'h1);
    chk("cause", {29'h0, cause}, 32'h7);
    $display("test sleep_hold done");
    tmr_en = 1'b1;
    tmr_ld = 32'h20;
    deep = 1'b1;
    sleep_in();
    chk("deep", {31'h0, deep_act}, 32'h1);
    tick(10);
    chk("state", {30'h0, state}, 32'h2);
    wait_state(2'h1);
    chk("cause", {29'h0, cause}, 32'h1);
    tmr_en = 1'b0;
    deep = 1'b0;
    // each wake source: disabled pins must not wake
    for (int i = 0; i < 5; i++) begin
      en = 3'h0;
      sleep_in();
      if (i >= 2) begin
        src[i] = 1'b1;
        tick(10);
        chk("state", {30'h0, state}, 32'h2);
      end
      en = 3'h7;
      src[i] = 1'b1;
      wait_state(2'h1);
      chk("cause", {29'h0, cause}, 32'(i + 2));
      src = 5'h0;
    end
    $display("test wake done");
    sw_off = 1'b1;
    tick(1);
    sw_off = 1'b0;
    tick(1);
    chk("rst_n", {31'h0, rst_n}, 32'h0);
    chk("permit", {31'h0, permit}, 32'h1);
    wait_state(2'h0);
    chk("permit", {31'h0, permit}, 32'h0);
    chk("pwr_en", {31'h0, pwr_en}, 32'h0);
    chk("rail_on", {31'h0, rail_on}, 32'h0);
    $display("test sw_off done");
    power_up();
    ot = 1'b1;
    tick(1);
    ot = 1'b0;
    wait_state(2'h0);
    power_up();
    sleep_in();
    bo = 1'b1;
    tick(1);
    bo = 1'b0;
    wait_state(2'h0);
    chk("pwr_en", {31'h0, pwr_en}, 32'h0);
    $display("test hw_off done");
    test_done();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    $display("watchdog expired");
    test_done();
  end
endmodule
